/* File: design/spimp_top.sv */
// serial master port: apb register file, clock divider, shifter, selects, interrupt
// assumes one clock, inputs synchronous to it, and an apb master on the bus side
//
// Contract
// - master only, drives clock and selects
// - full duplex characters of 1 to 32 bits
// - three separate slave select outputs
// - frame of 1 to 4096 characters
// - select to first bit delay 0-3 clocks
// - optional interrupt on each character done
// - serial clock divided from system clock
// - polarity and clock edge programmable
// - loopback feeds transmit data into receive
// - no dma requests, processor moves data
// - mode 0 is cpha 0, mode 1 cpha 1
`timescale 1ns/1ps
`default_nettype none
`include "spimp_map.svh"

module spimp_top #(
  parameter int NUM_CS = 3,
  parameter int MAX_CHAR = 32,
  parameter int MAX_FRAME = 4096
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire spimp_pkg::spimp_apb_req_t apb_req,
  output var spimp_pkg::spimp_apb_rsp_t apb_rsp,
  output logic ser_clk,
  output logic ser_out,
  input wire logic ser_in,
  output logic [2:0] slave_select_pins,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  generate
    if (NUM_CS != 3 || MAX_CHAR != 32 || MAX_FRAME != 4096) begin : g_bad
      $error("spimp_top: only 3 selects, 32-bit characters, 4096-char frames");
    end
  endgenerate

  spimp_pkg::spimp_regs_t r, n;

  logic tick;
  logic [1:0] sel;
  logic cpol;
  logic cpha;
  logic [5:0] last_h;
  logic rx_bit;
  logic setup;
  logic access;
  logic [13:0] idx;
  logic go;
  logic [2:0] cs_pol;

  // decode of current configuration
  assign tick = (r.div == 16'h0000);
  assign sel = (r.cs_act == `SPIMP_CS_NONE) ? 2'h0 : r.cs_act;
  assign cpol = r.cfg1[`SPIMP_CFG1_CKP_LO + sel];
  assign cpha = r.cfg1[`SPIMP_CFG1_CKPH_LO + sel];
  assign last_h = {r.cmd2[6:2], 1'b1};
  assign rx_bit = r.cfg2[`SPIMP_CFG2_LOOP] ? r.mosi : ser_in;
  assign setup = apb_req.psel && !apb_req.penable;
  assign access = apb_req.psel && apb_req.penable && r.rsp.pready;
  assign idx = apb_req.paddr[15:2];
  assign cs_pol = r.cfg1[`SPIMP_CFG1_CSPOL_LO +: 3];
  // a go bit starts one character when idle or between characters
  assign go = access && apb_req.pwrite && idx == `SPIMP_IDX_CMD2
    && apb_req.pwdata[`SPIMP_CMD2_GO] && r.clkctl[`SPIMP_CLKCTL_EN]
    && (r.st == spimp_pkg::ST_IDLE || r.st == spimp_pkg::ST_GAP)
    && (r.st == spimp_pkg::ST_GAP || apb_req.pwdata[1:0] != `SPIMP_CS_NONE);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [1:0] ev;
    logic [31:0] rd;
    logic hit;
    ev = 2'h0;
    rd = 32'h0000_0000;
    hit = 1'b1;
    n = r;
    // divider for half periods of the serial clock
    if (r.st == spimp_pkg::ST_IDLE || r.st == spimp_pkg::ST_GAP || tick) begin
      n.div = r.clkdiv;
    end else begin
      n.div = r.div - 16'h0001;
    end
    // apb setup phase: answer one cycle later
    n.rsp.pready = setup;
    n.rd_clr = 2'h0;
    if (setup) begin
      unique case (idx)
        `SPIMP_IDX_CLKDIV: rd = {16'h0000, r.clkdiv};
        `SPIMP_IDX_CLKCTL: rd = {16'h0000, r.clkctl};
        `SPIMP_IDX_DEVCFG1: rd = {16'h0000, r.cfg1};
        `SPIMP_IDX_DEVCFG2: rd = {16'h0000, r.cfg2};
        `SPIMP_IDX_CMD1: rd = {16'h0000, r.cmd1};
        `SPIMP_IDX_CMD2: rd = {16'h0000, r.cmd2};
        `SPIMP_IDX_STAT1: rd = {30'h0000_0000, r.st == spimp_pkg::ST_GAP,
          r.st != spimp_pkg::ST_IDLE && r.st != spimp_pkg::ST_GAP};
        `SPIMP_IDX_STAT2: rd = {20'h0_0000, r.chars};
        `SPIMP_IDX_DATA1: rd = {16'h0000, r.rxd[15:0]};
        `SPIMP_IDX_DATA2: rd = {16'h0000, r.rxd[31:16]};
        `SPIMP_IDX_IRQSTAT: rd = {30'h0000_0000, r.irq_st};
        `SPIMP_IDX_IRQMASK: rd = {30'h0000_0000, r.irq_mask};
        default: hit = 1'b0;
      endcase
      n.rsp.prdata = rd;
      n.rsp.pslverr = !hit || apb_req.paddr[1:0] != 2'h0;
      if (!apb_req.pwrite && hit && idx == `SPIMP_IDX_IRQSTAT) begin
        n.rd_clr = r.irq_st;
      end
    end
    // apb access phase: writes take effect here
    if (access && apb_req.pwrite && !r.rsp.pslverr) begin
      unique case (idx)
        `SPIMP_IDX_CLKDIV: n.clkdiv = apb_req.pwdata[15:0];
        `SPIMP_IDX_CLKCTL: n.clkctl = apb_req.pwdata[15:0];
        `SPIMP_IDX_DEVCFG1: n.cfg1 = apb_req.pwdata[15:0];
        `SPIMP_IDX_DEVCFG2: n.cfg2 = apb_req.pwdata[15:0];
        `SPIMP_IDX_CMD1: n.cmd1 = apb_req.pwdata[15:0];
        `SPIMP_IDX_DATA1: n.txd[15:0] = apb_req.pwdata[15:0];
        `SPIMP_IDX_DATA2: n.txd[31:16] = apb_req.pwdata[15:0];
        `SPIMP_IDX_IRQMASK: n.irq_mask = apb_req.pwdata[1:0];
        default: n.clkctl = r.clkctl;
      endcase
    end
    // transfer sequencer
    unique case (r.st)
      spimp_pkg::ST_IDLE, spimp_pkg::ST_GAP: begin
        if (go) begin
          if (r.st == spimp_pkg::ST_IDLE) begin
            n.cs_act = apb_req.pwdata[1:0];
          end
          n.cmd2 = {8'h00, 1'b0, apb_req.pwdata[6:0]};
          // left align the character so bit 31 leads
          n.tsh = r.txd << (5'd31 - apb_req.pwdata[6:2]);
          n.lead = {r.cfg1[`SPIMP_CFG1_DLY_LO +: 2], 1'b0};
          n.hcnt = 6'h00;
          n.st = spimp_pkg::ST_LEAD;
        end
      end
      spimp_pkg::ST_LEAD: begin
        if (tick) begin
          if (r.lead == 3'h0) begin
            n.mosi = r.tsh[31];
            n.st = spimp_pkg::ST_SHIFT;
          end else begin
            n.lead = r.lead - 3'h1;
          end
        end
      end
      spimp_pkg::ST_SHIFT: begin
        if (tick) begin
          n.sclk = !r.sclk;
          n.hcnt = r.hcnt + 6'h01;
          if (r.hcnt[0] ^ cpha) begin
            // launch edge: trailing for cpha 0, leading for cpha 1
            n.mosi = cpha ? r.tsh[31] : r.tsh[30];
            n.tsh = r.tsh << 1;
          end else begin
            n.rsh = {r.rsh[30:0], rx_bit};
          end
          if (r.hcnt == last_h) begin
            // last half period samples only in phase 1, so its bit is merged here
            n.rxd = cpha ? {r.rsh[30:0], rx_bit} : r.rsh;
            n.hcnt = 6'h00;
            n.chars = r.chars + 12'h001;
            ev[`SPIMP_IRQ_CHAR] = r.cmd1[`SPIMP_CMD1_CIE];
            if (r.chars == r.cmd1[`SPIMP_CMD1_FLEN_HI:0]) begin
              n.st = spimp_pkg::ST_TRAIL;
            end else begin
              n.st = spimp_pkg::ST_GAP;
            end
          end
        end
      end
      spimp_pkg::ST_TRAIL: begin
        if (tick) begin
          n.cs_act = `SPIMP_CS_NONE;
          n.chars = 12'h000;
          ev[`SPIMP_IRQ_FRAME] = 1'b1;
          n.st = spimp_pkg::ST_IDLE;
        end
      end
    endcase
    // idle clock level follows polarity of the chosen slave, or of slave 0 when none is chosen
    if (n.st == spimp_pkg::ST_IDLE || n.st == spimp_pkg::ST_LEAD || n.st == spimp_pkg::ST_GAP) begin
      n.sclk = r.cfg1[`SPIMP_CFG1_CKP_LO + ((n.cs_act == `SPIMP_CS_NONE) ? 2'h0 : n.cs_act)];
    end
    // a new event wins over the read clear
    n.irq_st = (r.irq_st & ~(access ? r.rd_clr : 2'h0)) | ev;
    n.irq = |(n.irq_st & n.irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // select pins, one per slave, each with its own polarity
  // polarity comes from the next configuration so a write to it
  // moves the idle level at the same edge as the register itself
  logic [2:0] cs_nxt;
  logic [2:0] cs_pol_nxt;
  assign cs_pol_nxt = n.cfg1[`SPIMP_CFG1_CSPOL_LO +: 3];
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cs
      assign cs_nxt[gi] = (n.cs_act == 2'(gi)) ? cs_pol_nxt[gi] : !cs_pol_nxt[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
      r.st <= spimp_pkg::ST_IDLE;
      r.cs_act <= `SPIMP_CS_NONE;
      r.cs_pins <= `SPIMP_RST_CS_PINS;
    end else begin
      r <= n;
      r.cs_pins <= cs_nxt;
    end
  end

  // outputs straight from flops; no dma request port exists
  assign apb_rsp = r.rsp;
  assign ser_clk = r.sclk;
  assign ser_out = r.mosi;
  assign slave_select_pins = r.cs_pins;
  assign irq = r.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_idle_no_select: assert property (@(posedge clk_sys) disable iff (!rst_b)
    r.st == spimp_pkg::ST_IDLE && $past(r.st) == spimp_pkg::ST_IDLE
      |-> slave_select_pins == ~cs_pol)
    else $error("select active while idle");

  // the chosen select is already active while the lead delay runs
  chk_lead_select: assert property (@(posedge clk_sys) disable iff (!rst_b)
    r.st == spimp_pkg::ST_LEAD |-> slave_select_pins[sel] == cs_pol[sel])
    else $error("select not active during lead delay");

  chk_one_select: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $onehot0(slave_select_pins ^ ~cs_pol))
    else $error("more than one select active");

  chk_select_held: assert property (@(posedge clk_sys) disable iff (!rst_b)
    r.st == spimp_pkg::ST_GAP |-> r.cs_act != `SPIMP_CS_NONE ##1 r.cs_act == $past(r.cs_act))
    else $error("select dropped inside frame");

  chk_clock_on_tick: assert property (@(posedge clk_sys) disable iff (!rst_b)
    r.st == spimp_pkg::ST_SHIFT && !tick |=> ser_clk == $past(ser_clk))
    else $error("serial clock moved off divider tick");

  chk_first_edge: assert property (@(posedge clk_sys) disable iff (!rst_b)
    r.st == spimp_pkg::ST_SHIFT && r.hcnt == 6'h00 && tick |=> ser_clk != cpol)
    else $error("first edge did not leave idle level");

  chk_lead_done: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(r.st == spimp_pkg::ST_SHIFT) |-> $past(r.lead) == 3'h0 && $past(tick))
    else $error("shift began before lead delay");

  chk_char_end: assert property (@(posedge clk_sys) disable iff (!rst_b)
    r.st == spimp_pkg::ST_SHIFT && tick && r.hcnt == last_h |=> r.st != spimp_pkg::ST_SHIFT)
    else $error("character ran past its length");

  chk_frame_end: assert property (@(posedge clk_sys) disable iff (!rst_b)
    r.st == spimp_pkg::ST_TRAIL |-> r.chars == r.cmd1[11:0] + 12'h001)
    else $error("frame ended at wrong count");

  chk_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_b)
    irq == |(r.irq_st & r.irq_mask))
    else $error("interrupt not tied to masked status");

  chk_ready_pulse: assert property (@(posedge clk_sys) disable iff (!rst_b)
    apb_rsp.pready |-> $past(setup) ##1 !apb_rsp.pready)
    else $error("pready not a single cycle answer");

endmodule : spimp_top
`default_nettype wire

/* File: include/spimp_map.svh */
// register indices, field positions and reset values of the serial master port
// assumes the includer adds the two zero address bits itself (byte address = 4 * index)
`ifndef SPIMP_MAP_SVH
`define SPIMP_MAP_SVH

// register indices, byte address is four times the index
`define SPIMP_IDX_CLKDIV 14'h3000
`define SPIMP_IDX_CLKCTL 14'h3001
`define SPIMP_IDX_DEVCFG1 14'h3002
`define SPIMP_IDX_DEVCFG2 14'h3003
`define SPIMP_IDX_CMD1 14'h3004
`define SPIMP_IDX_CMD2 14'h3005
`define SPIMP_IDX_STAT1 14'h3006
`define SPIMP_IDX_STAT2 14'h3007
`define SPIMP_IDX_DATA1 14'h3008
`define SPIMP_IDX_DATA2 14'h3009
`define SPIMP_IDX_IRQSTAT 14'h300a
`define SPIMP_IDX_IRQMASK 14'h300b

// field positions
`define SPIMP_CLKCTL_EN 0
`define SPIMP_CFG1_CKP_LO 0
`define SPIMP_CFG1_CKPH_LO 4
`define SPIMP_CFG1_CSPOL_LO 8
`define SPIMP_CFG1_DLY_LO 12
`define SPIMP_CFG2_LOOP 0
`define SPIMP_CMD1_FLEN_HI 11
`define SPIMP_CMD1_CIE 14
`define SPIMP_CMD2_CS_HI 1
`define SPIMP_CMD2_LEN_LO 2
`define SPIMP_CMD2_GO 7
`define SPIMP_IRQ_CHAR 0
`define SPIMP_IRQ_FRAME 1

// reset values
`define SPIMP_RST_REG16 16'h0000
`define SPIMP_RST_CS_PINS 3'h7
`define SPIMP_CS_NONE 2'h3

`endif

/* File: include/spimp_pkg.sv */
// types of the serial master port: bus carriers, states and the state record
// assumes nothing beyond a standard elaborator
package spimp_pkg;

  typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_SHIFT, ST_GAP, ST_TRAIL} spimp_state_t;

  // apb request and answer
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } spimp_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } spimp_apb_rsp_t;

  // whole state of the port
  typedef struct packed {
    spimp_state_t st;
    logic [15:0] clkdiv;
    logic [15:0] clkctl;
    logic [15:0] cfg1;
    logic [15:0] cfg2;
    logic [15:0] cmd1;
    logic [15:0] cmd2;
    logic [31:0] txd;
    logic [31:0] rxd;
    logic [31:0] tsh;
    logic [31:0] rsh;
    logic [15:0] div;
    logic [2:0] lead;
    logic [5:0] hcnt;
    logic [11:0] chars;
    logic [1:0] cs_act;
    logic sclk;
    logic mosi;
    logic [2:0] cs_pins;
    logic [1:0] irq_st;
    logic [1:0] irq_mask;
    logic irq;
    logic [1:0] rd_clr;
    spimp_apb_rsp_t rsp;
  } spimp_regs_t;

endpackage : spimp_pkg

/* File: test/spimp_slave_model.sv */
// behavioural slave on the far side of the serial link, clock polarity 0 only
// assumes the bench chooses which select it listens to, the phase and the word
`timescale 1ns/1ps
`default_nettype none
module spimp_slave_model (
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic cpha,
  input wire logic mosi,
  input wire logic [31:0] tx_word,
  input wire logic [5:0] nbits,
  output logic miso,
  output logic [31:0] rx_word
);
  int idx;
  initial miso = 1'b0;
  // select taken: phase 0 shows the msb at once
  always @(negedge ss_n) begin
    idx = nbits - 1;
    rx_word = '0;
    if (!cpha) miso = tx_word[idx];
  end
  // leading edge: sample in phase 0, launch in phase 1
  always @(posedge sclk) if (!ss_n) begin
    if (!cpha) rx_word = {rx_word[30:0], mosi};
    else if (idx >= 0) miso = tx_word[idx];
  end
  // trailing edge: launch next in phase 0, sample in phase 1
  always @(negedge sclk) if (!ss_n) begin
    if (cpha) rx_word = {rx_word[30:0], mosi};
    idx--;
    if (!cpha && idx >= 0) miso = tx_word[idx];
  end
  // released line has no pull, so show the inverse of the last bit
  always @(posedge ss_n) miso = ~miso;
endmodule : spimp_slave_model
`default_nettype wire

/* File: test/spi_master_port_tb.sv */
// self-checking bench: apb tasks, register checks, two character scenarios, loopback frame
// assumes the design package, the map header and the slave model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "spimp_map.svh"
module spi_master_port_tb;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  spimp_pkg::spimp_apb_req_t apb_req = '0;
  spimp_pkg::spimp_apb_rsp_t apb_rsp;
  logic ser_clk, ser_out, ser_in, irq, e;
  logic [2:0] slave_select_pins;
  logic [1:0] sel = 2'h0;
  logic m_cpha = 1'b0;
  logic [31:0] m_tx = '0;
  logic [5:0] m_bits = 6'h08;
  logic [31:0] m_rx, v, w;
  int n_errors = 0;
  int checks = 0;
  ////////////////////////////////////////////////////////////////////////////////
  spimp_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .ser_clk(ser_clk), .ser_out(ser_out), .ser_in(ser_in),
    .slave_select_pins(slave_select_pins), .irq(irq));
  spimp_slave_model slave (.sclk(ser_clk), .ss_n(slave_select_pins[sel]), .cpha(m_cpha),
    .mosi(ser_out), .tx_word(m_tx), .nbits(m_bits), .miso(ser_in), .rx_word(m_rx));
  // 25 mhz system clock
  always #20 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; answer is taken at the rising edge that samples pready high
  task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk_sys);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00}, pwdata: wd};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    chk({31'h0, apb_rsp.pready}, 32'h1);
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [13:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic x;
    apb(1'b1, idx, d, r, x);
  endtask : wr
  task automatic rd(input logic [13:0] idx, output logic [31:0] r);
    logic x;
    apb(1'b0, idx, 32'h0, r, x);
  endtask : rd
  // load a character, start it and poll until the port is no longer busy
  task automatic go_char(input logic [1:0] s, input logic [4:0] lm1, input logic [31:0] d);
    int n;
    wr(`SPIMP_IDX_DATA1, {16'h0, d[15:0]});
    wr(`SPIMP_IDX_DATA2, {16'h0, d[31:16]});
    wr(`SPIMP_IDX_CMD2, {24'h0, 1'b1, lm1, s});
    n = 0;
    do begin
      rd(`SPIMP_IDX_STAT1, v);
      n++;
    end while (v[0] !== 1'b0 && n < 300);
    chk({31'h0, v[0]}, 32'h0);
  endtask : go_char
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    give_verdict;
  end
  // main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    chk({29'h0, slave_select_pins}, 32'h7);
    rd(`SPIMP_IDX_DEVCFG1, v);
    chk(v, 32'h0);
    wr(`SPIMP_IDX_CLKDIV, 32'h1);
    rd(`SPIMP_IDX_CLKDIV, v);
    chk(v, 32'h1);
    apb(1'b1, 14'h300c, 32'h5, v, e);
    chk({31'h0, e}, 32'h1);
    wr(`SPIMP_IDX_STAT2, 32'hffff);
    rd(`SPIMP_IDX_STAT2, v);
    chk(v, 32'h0);
    $display("test registers done");
    // mode 0, slave 0, 8 bits, character interrupt unmasked
    wr(`SPIMP_IDX_CLKCTL, 32'h1);
    wr(`SPIMP_IDX_CMD1, 32'h4000);
    wr(`SPIMP_IDX_IRQMASK, 32'h1);
    m_tx = 32'h3c;
    go_char(2'h0, 5'd7, 32'ha5);
    rd(`SPIMP_IDX_DATA1, v);
    chk({24'h0, v[7:0]}, 32'h3c);
    chk(m_rx, 32'ha5);
    chk({29'h0, slave_select_pins}, 32'h7);
    chk({31'h0, irq}, 32'h1);
    rd(`SPIMP_IDX_IRQSTAT, v);
    chk(v, 32'h3);
    rd(`SPIMP_IDX_IRQSTAT, v);
    chk(v, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test mode0 done");
    // mode 1, slave 1, 32 bits, lead delay 3, character interrupt off
    wr(`SPIMP_IDX_DEVCFG1, 32'h3020);
    wr(`SPIMP_IDX_CMD1, 32'h0);
    m_tx = 32'hdeadbeef;
    m_bits = 6'd32;
    m_cpha = 1'b1;
    sel = 2'h1;
    go_char(2'h1, 5'd31, 32'h80000001);
    rd(`SPIMP_IDX_DATA1, v);
    rd(`SPIMP_IDX_DATA2, w);
    chk({w[15:0], v[15:0]}, 32'hdeadbeef);
    chk(m_rx, 32'h80000001);
    chk({31'h0, irq}, 32'h0);
    rd(`SPIMP_IDX_IRQSTAT, v);
    chk(v, 32'h2);
    $display("test mode1 done");
    // loopback frame of two characters on slave 2 with active high select
    wr(`SPIMP_IDX_DEVCFG2, 32'h1);
    wr(`SPIMP_IDX_DEVCFG1, 32'h0400);
    wr(`SPIMP_IDX_CMD1, 32'h1);
    go_char(2'h2, 5'd0, 32'h1);
    rd(`SPIMP_IDX_STAT1, v);
    chk(v, 32'h2);
    chk({29'h0, slave_select_pins}, 32'h7);
    rd(`SPIMP_IDX_STAT2, v);
    chk(v, 32'h1);
    rd(`SPIMP_IDX_DATA1, v);
    chk({31'h0, v[0]}, 32'h1);
    go_char(2'h2, 5'd15, 32'h1234);
    rd(`SPIMP_IDX_DATA1, v);
    chk({16'h0, v[15:0]}, 32'h1234);
    chk({29'h0, slave_select_pins}, 32'h3);
    rd(`SPIMP_IDX_IRQSTAT, v);
    chk(v, 32'h2);
    $display("test loopback frame done");
    give_verdict;
  end
endmodule : spi_master_port_tb
`default_nettype wire
